// ===== flash_ctl_pkg.sv
/*
 * constants, types and step table of the flash status/continuity controller
 * assumes a parallel NOR flash on plain pins and software on APB
 */
// Summary of operation
// RULE1: the flash compares two inverted all-line pattern writes for continuity
// RULE2: a correct pattern pair sets flash status bit 0
// RULE3: host puts the die choice on address bit 26 for every cycle
// RULE4: host writes clear code, then status-read code, then checks bit 0 is zero
// RULE5: x16 patterns are FF00 at 2AAAA55, then 00FF at 15555AA
// RULE6: x8 uses status address AAA, FF at 55554AB, then 00 at 2AAAB54
// RULE7: after patterns host issues status read; bit 0 one means continuity passed
// RULE8: the flash holds one 16-bit status word, read only via status read
// RULE9: status-read command captures status on rising write strobe, enters overlay
// RULE10: in the overlay every address returns the captured status word
// RULE11: first read ends the overlay on rising chip or output enable
// RULE12: x8 host reads both bytes by toggling byte select with strobes held
// RULE13: the flash ignores writes while in the overlay
// RULE14: result flags: erase fail 5, program fail 4, buffer abort 3, locked 1
// RULE15: live flags: ready 7, erase suspended 6, program suspended 2
// RULE16: status bits 15 to 8 are reserved and masked by the host
// RULE17: soft reset clears bits 5,4,1,0 only when bit 3 is zero
// RULE18: clear status zeroes bits 5,4,3,1,0, live bits untouched
// RULE19: the flash offers status word, data polling and ready/busy pin together
// RULE20: bit 7 reads one when no embedded algorithm runs
// RULE21: bits 6 to 1 are valid only while bit 7 reads one
// RULE22: reset puts ready at bit 7 and other defined bits at zero
// RULE23: a wrong pattern pair leaves the continuity flag unchanged
package flash_ctl_pkg;
	// apb map
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_SWORD  = 12'h008;
	// ctrl fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_START  = 2;
	localparam int CTRL_X8     = 3;
	localparam int CTRL_DIE    = 4;
	// status fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_PASS = 2;
	localparam int ST_CHK0 = 3;
	localparam int ST_RDY  = 4;
	// flash status bits
	localparam int FS_READY = 7;
	localparam int FS_CONT  = 0;
	localparam logic [7:0] FS_MASK = 8'hFF;
	// operations
	localparam logic [1:0] OP_STATUS = 2'h0;
	localparam logic [1:0] OP_CONT   = 2'h1;
	localparam logic [1:0] OP_CLEAR  = 2'h2;
	localparam logic [1:0] OP_RESET  = 2'h3;
	localparam logic [2:0] CONT_READ0 = 3'h2;
	localparam logic [2:0] CONT_PAT1  = 3'h3;
	localparam logic [2:0] CONT_SRCMD = 3'h5;
	localparam logic [2:0] CONT_READ1 = 3'h6;
	// flash addresses, raw as A25..A0 (x16) or A25..A-1 (x8)
	localparam logic [26:0] A_UNLOCK = 27'h0000555;
	localparam logic [26:0] A_SR8    = 27'h0000AAA;
	localparam logic [26:0] A_PAT1W  = 27'h2AAAA55;
	localparam logic [26:0] A_PAT2W  = 27'h15555AA;
	localparam logic [26:0] A_PAT1B  = 27'h55554AB;
	localparam logic [26:0] A_PAT2B  = 27'h2AAAB54;
	localparam logic [26:0] A_ZERO   = 27'h0000000;
	// flash data
	localparam logic [15:0] CMD_CLEAR = 16'h0071;
	localparam logic [15:0] CMD_SR    = 16'h0070;
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [15:0] D_PAT1W   = 16'hFF00;
	localparam logic [15:0] D_PAT2W   = 16'h00FF;
	localparam logic [15:0] D_PAT1B   = 16'h00FF;
	localparam logic [15:0] D_PAT2B   = 16'h0000;
	// timing
	localparam int CLK_MHZ    = 100;
	localparam int T_SETUP_NS = 10;
	localparam int T_WP_NS    = 50;
	localparam int T_ACC_NS   = 100;
	localparam int T_REC_NS   = 30;
	localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WP_CYC    = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ACC_CYC   = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] REC_CYC   = 8'((T_REC_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [1:0] {K_END = 2'b00, K_WR = 2'b01, K_RD = 2'b10} kind_t;
	typedef struct packed {
		kind_t       kind;
		logic [26:0] raw;
		logic [15:0] data;
	} step_t;
	typedef enum logic [2:0] {
		P_IDLE  = 3'b000,
		P_ISSUE = 3'b001,
		P_SETUP = 3'b010,
		P_WSTB  = 3'b011,
		P_RLO   = 3'b100,
		P_RHI   = 3'b101,
		P_REC   = 3'b110
	} phase_t;

	// bus cycle list of each operation
	function automatic step_t step_of(input logic [1:0] op, input logic [2:0] idx,
		input logic x8);
		step_t       s;
		logic [26:0] sra;
		s   = '{K_END, A_ZERO, 16'h0000};
		sra = x8 ? A_SR8 : A_UNLOCK;
		case (op)
			OP_STATUS: begin
				if (idx == 3'h0) s = '{K_WR, sra, CMD_SR};
				else if (idx == 3'h1) s = '{K_RD, A_ZERO, 16'h0000};
			end
			OP_CLEAR: begin
				if (idx == 3'h0) s = '{K_WR, A_UNLOCK, CMD_CLEAR};
			end
			OP_RESET: begin
				if (idx == 3'h0) s = '{K_WR, A_ZERO, CMD_RESET};
			end
			default: begin
				case (idx)
					3'h0: s = '{K_WR, A_UNLOCK, CMD_CLEAR};
					3'h1: s = '{K_WR, sra, CMD_SR};
					3'h2: s = '{K_RD, A_ZERO, 16'h0000};
					3'h3: begin
						if (x8) s = '{K_WR, A_PAT1B, D_PAT1B};
						else s = '{K_WR, A_PAT1W, D_PAT1W};
					end
					3'h4: begin
						if (x8) s = '{K_WR, A_PAT2B, D_PAT2B};
						else s = '{K_WR, A_PAT2W, D_PAT2W};
					end
					3'h5: s = '{K_WR, sra, CMD_SR};
					3'h6: s = '{K_RD, A_ZERO, 16'h0000};
					default: s = '{K_END, A_ZERO, 16'h0000};
				endcase
			end
		endcase
		return s;
	endfunction : step_of
endpackage : flash_ctl_pkg

// ===== flash_ctl.sv
/*
 * host controller that runs status reads, clears, soft resets and the
 * continuity check on a parallel NOR flash; software drives it over APB
 * assumes pins synchronous to pclk and flash timing met by the package counts
 */
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns
module flash_ctl #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// flash pins
	output logic      [26:0] flash_addr,
	output logic             flash_bsel,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	output logic             flash_we_n,
	output logic             flash_word_mode,
	output logic      [15:0] flash_dq_out,
	output logic             flash_dq_oe_n,
	input  wire logic [15:0] flash_dq_in,
	input  wire logic        ready_busy_pin
);
	import flash_ctl_pkg::*;

	if (CNT_W < 8) begin : g_chk
		$error("CNT_W too small for timing counts");
	end

	typedef struct packed {
		phase_t      phase;
		logic [1:0]  op;
		logic [2:0]  step;
		logic [7:0]  cnt;
		logic        is_rd;
		logic        x8;
		logic        die;
		logic        busy;
		logic        done;
		logic        pass;
		logic        chk0;
		logic [7:0]  status;
		logic [26:0] addr;
		logic        bsel;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        dq_oe_n;
		logic [15:0] dq_out;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} state_t;

	localparam state_t RESET_STATE = '{P_IDLE, OP_STATUS, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0,
		1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 27'h0000000, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
		16'h0000, 1'b0, 1'b0, 32'h00000000};

	state_t s;
	state_t next_s;
	step_t  st;
	logic [7:0] v;

	always_comb begin
		next_s         = s;
		next_s.pready  = 1'b0;
		next_s.pslverr = 1'b0;
		st             = step_of(s.op, s.step, s.x8);
		v              = flash_dq_in[7:0] & FS_MASK;
		// apb access, answered one cycle into the access phase
		if (psel && penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h00000000;
			if (pwrite) begin
				if (paddr == REG_CTRL) begin
					if (!s.busy) begin
						next_s.op  = pwdata[CTRL_OP_LSB +: 2];
						next_s.x8  = pwdata[CTRL_X8];
						next_s.die = pwdata[CTRL_DIE];
						if (pwdata[CTRL_START]) begin
							next_s.busy  = 1'b1;
							next_s.done  = 1'b0;
							next_s.pass  = 1'b0;
							next_s.chk0  = 1'b0;
							next_s.step  = 3'h0;
							next_s.phase = P_ISSUE;
						end
					end
				end else if (paddr != REG_STATUS && paddr != REG_SWORD) begin
					next_s.pslverr = 1'b1;
				end
			end else begin
				if (paddr == REG_CTRL) begin
					next_s.prdata[CTRL_OP_LSB +: 2] = s.op;
					next_s.prdata[CTRL_X8]          = s.x8;
					next_s.prdata[CTRL_DIE]         = s.die;
				end else if (paddr == REG_STATUS) begin
					next_s.prdata[ST_BUSY] = s.busy;
					next_s.prdata[ST_DONE] = s.done;
					next_s.prdata[ST_PASS] = s.pass;
					next_s.prdata[ST_CHK0] = s.chk0;
					next_s.prdata[ST_RDY]  = ready_busy_pin;
				end else if (paddr == REG_SWORD) begin
					next_s.prdata[7:0] = s.status; // RULE16
				end else begin
					next_s.pslverr = 1'b1;
				end
			end
		end
		// flash bus sequencer
		case (s.phase)
			P_ISSUE: begin
				if (st.kind == K_END) begin
					next_s.busy  = 1'b0;
					next_s.done  = 1'b1;
					next_s.phase = P_IDLE;
				end else begin
					next_s.addr    = s.x8 ? {s.die, st.raw[26:1]} : {s.die, st.raw[25:0]}; // RULE3
					next_s.bsel    = s.x8 ? st.raw[0] : 1'b0;
					next_s.dq_out  = st.data; // RULE4 RULE5 RULE6
					next_s.is_rd   = (st.kind == K_RD);
					next_s.dq_oe_n = (st.kind == K_RD);
					next_s.ce_n    = 1'b0;
					next_s.cnt     = SETUP_CYC - 8'h01;
					next_s.phase   = P_SETUP;
				end
			end
			P_SETUP: begin
				if (s.cnt != 8'h00) begin
					next_s.cnt = s.cnt - 8'h01;
				end else if (s.is_rd) begin
					next_s.oe_n  = 1'b0;
					next_s.cnt   = ACC_CYC - 8'h01;
					next_s.phase = P_RLO;
				end else begin
					next_s.we_n  = 1'b0;
					next_s.cnt   = WP_CYC - 8'h01;
					next_s.phase = P_WSTB;
				end
			end
			P_WSTB: begin
				if (s.cnt != 8'h00) begin
					next_s.cnt = s.cnt - 8'h01;
				end else begin
					next_s.we_n  = 1'b1;
					next_s.cnt   = REC_CYC - 8'h01;
					next_s.phase = P_REC;
				end
			end
			P_RLO: begin
				if (s.cnt != 8'h00) begin
					next_s.cnt = s.cnt - 8'h01;
				end else begin
					next_s.status = v; // RULE16
					if (s.op == OP_CONT && s.step == CONT_READ0) begin
						next_s.chk0 = v[FS_READY] && !v[FS_CONT]; // RULE4 RULE21
					end
					if (s.op == OP_CONT && s.step == CONT_READ1) begin
						next_s.pass = s.chk0 && v[FS_READY] && v[FS_CONT]; // RULE7 RULE21
					end
					if (s.x8) begin
						next_s.bsel  = 1'b1; // RULE12
						next_s.cnt   = ACC_CYC - 8'h01;
						next_s.phase = P_RHI;
					end else begin
						next_s.oe_n  = 1'b1;
						next_s.cnt   = REC_CYC - 8'h01;
						next_s.phase = P_REC;
					end
				end
			end
			P_RHI: begin
				// upper byte is reserved, discarded
				if (s.cnt != 8'h00) begin
					next_s.cnt = s.cnt - 8'h01;
				end else begin
					next_s.oe_n  = 1'b1;
					next_s.cnt   = REC_CYC - 8'h01;
					next_s.phase = P_REC;
				end
			end
			P_REC: begin
				next_s.ce_n    = 1'b1;
				next_s.dq_oe_n = 1'b1;
				if (s.cnt != 8'h00) begin
					next_s.cnt = s.cnt - 8'h01;
				end else begin
					next_s.step  = s.step + 3'h1;
					next_s.phase = P_ISSUE;
				end
			end
			P_IDLE: begin
				// waits for a start write
			end
			default: begin
				next_s.phase = P_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RESET_STATE;
		end else begin
			s <= next_s;
		end
	end

	assign prdata          = s.prdata;
	assign pready          = s.pready;
	assign pslverr         = s.pslverr;
	assign flash_addr      = s.addr;
	assign flash_bsel      = s.bsel;
	assign flash_ce_n      = s.ce_n;
	assign flash_oe_n      = s.oe_n;
	assign flash_we_n      = s.we_n;
	assign flash_word_mode = !s.x8;
	assign flash_dq_out    = s.dq_out;
	assign flash_dq_oe_n   = s.dq_oe_n;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	die_bit_a: assert property (!flash_ce_n |-> flash_addr[26] == s.die) // RULE3
		else $error("die select bit differs from chosen die");
	clear_first_a: assert property ($fell(flash_we_n) && s.op == OP_CONT && s.step == 3'h0 // RULE4
		|-> flash_dq_out == CMD_CLEAR)
		else $error("continuity check did not open with clear command");
	pat_word_a: assert property ($fell(flash_we_n) && s.op == OP_CONT && s.step == CONT_PAT1 // RULE5
		&& !s.x8 |-> flash_addr[25:0] == A_PAT1W[25:0] && flash_dq_out == D_PAT1W)
		else $error("x16 first pattern wrong");
	pat_byte_a: assert property ($fell(flash_we_n) && s.op == OP_CONT && s.step == CONT_PAT1 // RULE6
		&& s.x8 |-> {flash_addr[25:0], flash_bsel} == A_PAT1B && flash_dq_out[7:0] == 8'hFF)
		else $error("x8 first pattern wrong");
	verify_read_a: assert property ($rose(flash_we_n) && s.op == OP_CONT // RULE7
		&& s.step == CONT_SRCMD |-> ##[1:40] $fell(flash_oe_n))
		else $error("no status read after status command");
	byte_toggle_a: assert property ($rose(flash_bsel) && s.x8 && s.is_rd // RULE12
		|-> !flash_oe_n && !flash_ce_n && $past(!flash_oe_n))
		else $error("byte select toggled outside held read");
	pass_valid_a: assert property ($rose(s.pass) |-> s.status[FS_READY] // RULE21
		&& s.status[FS_CONT] && s.chk0)
		else $error("pass set without ready and continuity bit");
	strobe_len_a: assert property ($fell(flash_we_n) |-> !flash_we_n[*5] ##1 flash_we_n)
		else $error("write strobe width wrong");
	no_clash_a: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n)
		else $error("data driven during flash read");

	cont_pass_c: cover property ($rose(s.pass));
	byte_read_c: cover property (s.x8 && $rose(flash_bsel));
	status_done_c: cover property ($rose(s.done) && s.op == OP_STATUS);
	apb_err_c: cover property (pslverr);
endmodule : flash_ctl

// ===== flash_die.sv
/*
 * behavioural flash die: status word, status overlay, continuity detector
 * assumes strobes and address change only on pclk edges
 */
`timescale 1ns/1ns
module flash_die #(
	parameter logic DIE = 1'b0
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// flash pins
	input  wire logic [26:0] addr,
	input  wire logic        bsel,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        word_mode,
	input  wire logic [15:0] din,
	output logic      [15:0] dout,
	output logic             rdy,
	// status preload
	input  wire logic        ld,
	input  wire logic [7:0]  ld_val
);
	logic [7:0]  st;
	logic [7:0]  snap;
	logic        ovl;
	logic        we_q;
	logic        oe_q;
	logic        ce_q;
	logic        sel;
	logic        pair;
	logic [15:0] cnt;
	logic [15:0] d;
	logic [15:0] pd;
	logic [26:0] ra;
	logic [26:0] pa;
	assign sel = addr[26] == DIE;
	assign ra = word_mode ? {1'b0, addr[25:0]} : {addr[25:0], bsel};
	assign d = word_mode ? din : {8'h00, din[7:0]};
	assign rdy = st[7];
	// reserved byte and idle bus change every cycle
	assign dout = (sel && ovl && !ce_n && !oe_n) ?
		{cnt[15:8], (word_mode || !bsel) ? snap : cnt[7:0]} : cnt;
	assign pair = word_mode ?
		(pa == 27'h2AAAA55 && pd == 16'hFF00 && ra == 27'h15555AA && d == 16'h00FF) :
		(pa == 27'h55554AB && pd == 16'h00FF && ra == 27'h2AAAB54 && d == 16'h0000);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= 8'h80;
			snap <= 8'h00;
			ovl <= 1'b0;
			we_q <= 1'b1;
			oe_q <= 1'b1;
			ce_q <= 1'b1;
			cnt <= 16'h5A3C;
			pa <= 27'h0;
			pd <= 16'h0;
		end else begin
			cnt <= cnt + 16'h3C5B;
			we_q <= we_n;
			oe_q <= oe_n;
			ce_q <= ce_n;
			if (ld) st <= ld_val;
			if (sel && ovl && !ce_q && !oe_q && (oe_n || ce_n)) ovl <= 1'b0;
			if (sel && !ce_n && !we_q && we_n && !ovl) begin
				pa <= ra;
				pd <= d;
				if (d[7:0] == 8'h70) begin
					snap <= st;
					ovl <= 1'b1;
				end
				if (d[7:0] == 8'h71) st <= st & 8'hC4;
				if (d[7:0] == 8'hF0 && !st[3]) st <= st & 8'hCC;
				if (pair) st[0] <= 1'b1;
			end
		end
	end
endmodule : flash_die

// ===== test_flash_ctl.sv
/*
 * self-checking bench: apb master, two flash dies on one bus
 * assumes the controller's apb map and op codes from its package
 */
`timescale 1ns/1ns
module test_flash_ctl;
	import flash_ctl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [26:0] fa;
	logic        bsel, ce_n, oe_n, we_n, wm, dq_oe_n, rdy0, rdy1, ld0, ld1, e;
	logic [15:0] dq_out, dq_in, dout0, dout1;
	logic [7:0]  ld_val, v;
	int          fail_count, n_compared, cycles, k;
	assign dq_in = fa[26] ? dout1 : dout0;
	flash_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flash_addr(fa), .flash_bsel(bsel),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_word_mode(wm), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
		.flash_dq_in(dq_in), .ready_busy_pin(rdy0 & rdy1));
	flash_die #(.DIE(1'b0)) u_die0 (.pclk(pclk), .presetn(presetn), .addr(fa),
		.bsel(bsel), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .word_mode(wm),
		.din(dq_out), .dout(dout0), .rdy(rdy0), .ld(ld0), .ld_val(ld_val));
	flash_die #(.DIE(1'b1)) u_die1 (.pclk(pclk), .presetn(presetn), .addr(fa),
		.bsel(bsel), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .word_mode(wm),
		.din(dq_out), .dout(dout1), .rdy(rdy1), .ld(ld1), .ld_val(ld_val));
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic load(input logic [7:0] val, input logic die);
		@(posedge pclk);
		ld0 <= !die;
		ld1 <= die;
		ld_val <= val;
		@(posedge pclk);
		ld0 <= 1'b0;
		ld1 <= 1'b0;
	endtask : load
	task automatic run(input logic [1:0] op, input logic x8, input logic die,
		output logic [31:0] rd);
		logic [31:0] c;
		logic        er;
		int          i;
		c = {27'h0, die, x8, 1'b1, op};
		apb(1'b1, REG_CTRL, c, rd, er);
		apb(1'b1, REG_CTRL, 32'h1F, rd, er);
		apb(1'b0, REG_CTRL, 32'h0, rd, er);
		chk(rd, c & 32'hFB);
		i = 0;
		rd = 32'h0;
		while (rd[1] !== 1'b1 && i < 400) begin
			apb(1'b0, REG_STATUS, 32'h0, rd, er);
			i++;
		end
	endtask : run
	function automatic logic [7:0] want(input logic [1:0] op, input logic [7:0] s);
		case (op)
			2'h1: want = (s & 8'hC4) | 8'h01;
			2'h2: want = s & 8'hC4;
			2'h3: want = s[3] ? s : (s & 8'hCC);
			default: want = s;
		endcase
	endfunction : want
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
	end
	initial begin
		{presetn, psel, penable, pwrite, ld0, ld1} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		ld_val = 8'h0;
		{fail_count, n_compared} = {32'h0, 32'h0};
		r = $urandom(32'h73A6372A);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		fork
			begin
				apb(1'b0, REG_STATUS, 32'h0, r, e);
				chk(r, 32'h10);
				apb(1'b0, 12'hFFC, 32'h0, r, e);
				chk({r[31:1], r[0] ^ e}, 32'h1);
				for (k = 0; k < 16; k++) begin
					v = 8'($urandom) | 8'h80;
					load(v, k[3]);
					run(k[1:0], k[2], k[3], r);
					if (k[1:0] == OP_CONT) chk(r, 32'h1E);
					if (k[1:0] >= OP_CLEAR) run(OP_STATUS, k[2], k[3], r);
					apb(1'b0, REG_SWORD, 32'h0, r, e);
					chk(r, {24'h0, want(k[1:0], v)});
				end
				load(8'h04, 1'b0);
				run(OP_CONT, 1'b0, 1'b0, r);
				chk(r, 32'h02);
			end
			begin
				wait (cycles >= 30000);
				fail_count++;
				$display("BAD %0t timeout", $time);
			end
		join_any
		tally_and_finish;
	end
endmodule : test_flash_ctl
